// ===== core/salsr_defs.vh
`ifndef SALSR_DEFS_VH
`define SALSR_DEFS_VH

// word and buffer geometry
`define SALSR_WORD_W 16
`define SALSR_FIFO_DEPTH 16
`define SALSR_FIFO_AW 4

// reference clock period and fixed times
`define SALSR_CLK_PERIOD_NS 5
`define SALSR_T_CONV_NS 400
`define SALSR_T_PRE_END_NS 50
// least time, rounded up
`define SALSR_CONV_CYC ((`SALSR_T_CONV_NS + `SALSR_CLK_PERIOD_NS - 1) / `SALSR_CLK_PERIOD_NS)
// longest time, rounded down
`define SALSR_PRE_END_CYC (`SALSR_T_PRE_END_NS / `SALSR_CLK_PERIOD_NS)

// link rising edge numbers, counted from a frame marker rise
`define SALSR_EDGE_MSB 5'h02
`define SALSR_EDGE_HALF 5'h08
`define SALSR_EDGE_FULL 5'h10
`define SALSR_EDGE_LSB 5'h11
`define SALSR_EDGE_END 5'h12

// synchroniser bit positions and reset value
`define SALSR_SY_LVDS 0
`define SALSR_SY_CMOS 1
`define SALSR_SY_RD_N 2
`define SALSR_SY_CS_N 3
`define SALSR_SY_EXTCLK 4
`define SALSR_SY_HALF 5
`define SALSR_SY_CLKSRC 6
`define SALSR_SY_LP 7
`define SALSR_SYNC_RST 8'h0C

// conversion states
`define SALSR_CV_WAIT 2'h0
`define SALSR_CV_SAMPLE 2'h1
`define SALSR_CV_CONV 2'h2

// read states
`define SALSR_RD_IDLE 2'h0
`define SALSR_RD_LEAD 2'h1
`define SALSR_RD_SHIFT 2'h2

`endif

// ===== core/salsr_fifo.v
`timescale 1ns/1ps
`include "salsr_defs.vh"

module salsr_fifo #(
	parameter WIDTH = `SALSR_WORD_W,
	parameter DEPTH = `SALSR_FIFO_DEPTH,
	parameter AW = `SALSR_FIFO_AW
) (
	input wire clk,
	input wire nrst,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	localparam [AW:0] FULL_CNT = DEPTH[AW:0];

	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_q;
	reg [AW-1:0] rd_ptr_q;
	reg [AW:0] count_q;
	wire push;
	wire pop;

	// honest full and empty from the fill count
	assign in_ready = (count_q != FULL_CNT);
	assign out_valid = (count_q != {(AW+1){1'b0}});
	assign out_data = mem_q[rd_ptr_q];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// storage is written only on an accepted word
	always @(posedge clk)
	begin
		if (push)
			mem_q[wr_ptr_q] <= in_data;
	end

	// pointers and fill count
	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wr_ptr_q <= {AW{1'b0}};
			rd_ptr_q <= {AW{1'b0}};
			count_q <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_ptr_q <= wr_ptr_q + 1'b1;
			if (pop)
				rd_ptr_q <= rd_ptr_q + 1'b1;
			if (push & ~pop)
				count_q <= count_q + 1'b1;
			else if (pop & ~push)
				count_q <= count_q - 1'b1;
		end
	end
endmodule // salsr_fifo

// ===== core/salsr_readout.v
`timescale 1ns/1ps
`include "salsr_defs.vh"

// Functional notes
// - frame marker period is 16 link clocks, or 8 with half-frame select.
// - lvds and cmos convert-start inputs act identically, either may drive.
// - convert-start rise while waiting begins the sample phase.
// - convert-start rise during conversion starts sampling right at conversion end.
// - convert-start fall ends sampling and begins a fixed-length conversion; code holds its count at one while the buffer is full.
// - conversion-active output stays high throughout a conversion.
// - convert-start fall during conversion aborts it; following read is invalid.
// - result valid only after a complete sample and conversion.
// - read request fall with chip select low in wait/sample starts a read.
// - read start enables marker and serial outputs and raises bus-occupied.
// - bits counted after marker rise; MSB on edge 2, then each edge.
// - full frame: next marker rise on edge 16, LSB on edge 17.
// - half frame: marker period 8, next rise edge 8, bit 8 on edge 9.
// - half-frame mode works in every configuration.
// - chip select high during read tristates outputs until next read.
// - wait/sample read: marker starts low, rises a fixed delay later; code raises it on the first link rise with the buffer empty.
// - read pending or held low starts a read at the pre-end point.
// - end-of-conversion read: marker rises a fixed delay after conversion end; code raises it on the first link rise after the result is loaded.
// - clock source select high picks internal clock, low the external one.
// - chip select high keeps all data outputs except clock tristated.
// - on edge 18 serial and marker outputs return to tristate.
// - low-power idle high enters low power at conversion end until sampling.
module salsr_readout (
	input wire ref_clk,
	input wire nrst,
	input wire lvds_convert_start,
	input wire cmos_convert_start,
	input wire rd_n,
	input wire cs_n,
	input wire half_frame_sel,
	input wire clk_src_sel,
	input wire ext_clk_in,
	input wire low_power_idle,
	input wire [15:0] sar_result,
	output wire conv_active,
	output wire bus_busy,
	output wire result_valid,
	output wire low_power,
	output wire link_clk_out,
	output wire frame_out,
	output wire frame_out_oe,
	output wire serial_out,
	output wire serial_out_oe
);
	localparam integer CONV_I = `SALSR_CONV_CYC;
	localparam integer PRE_I = `SALSR_PRE_END_CYC;
	localparam [7:0] CONV_CYC = CONV_I[7:0];
	localparam [7:0] PRE_CYC = (PRE_I == 0) ? 8'h01 : PRE_I[7:0]; // pre-end point never at zero

	reg [7:0] sync1_q, sync2_q, conv_cnt_q;
	reg [15:0] shift_q, out_q;
	reg [4:0] edge_q;
	reg [1:0] cv_st_q, rd_st_q;
	reg start_prev_q, rd_n_prev_q, sample_pend_q, conv_active_q, valid_q, lp_q;
	reg int_clk_q, lclk_prev_q, link_clk_q, frame_q, frame_oe_q, ser_q, ser_oe_q;
	reg bus_busy_q, rd_pend_q, eoc_wait_q;
	wire start_lvl, start_rise, start_fall, rd_fall, cs_ok, sel_clk, link_rise;
	wire conv_done, conv_abort, pre_point, rd_idle, read_now, read_eoc;
	wire fifo_in_ready, fifo_out_valid, fifo_out_ready;
	wire [15:0] fifo_out_data;
	wire [4:0] edge_nx;
	// marker rises on multiples of the frame period within the word
	function frame_edge;
		input [4:0] n;
		input half;
		begin
			frame_edge = (n == `SALSR_EDGE_FULL) || (half && (n == `SALSR_EDGE_HALF));
		end
	endfunction

	// two-stage synchronisers for every pin input but nrst and sar_result
	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sync1_q <= `SALSR_SYNC_RST;
			sync2_q <= `SALSR_SYNC_RST;
		end
		else
		begin
			sync1_q <= {low_power_idle, clk_src_sel, half_frame_sel, ext_clk_in,
				cs_n, rd_n, cmos_convert_start, lvds_convert_start};
			sync2_q <= sync1_q;
		end
	end

	// either start input steers sampling
	assign start_lvl = sync2_q[`SALSR_SY_LVDS] | sync2_q[`SALSR_SY_CMOS];
	assign start_rise = start_lvl & ~start_prev_q;
	assign start_fall = ~start_lvl & start_prev_q;
	assign rd_fall = ~sync2_q[`SALSR_SY_RD_N] & rd_n_prev_q;
	assign cs_ok = ~sync2_q[`SALSR_SY_CS_N];
	// link clock source and its rising edges
	assign sel_clk = sync2_q[`SALSR_SY_CLKSRC] ? int_clk_q : sync2_q[`SALSR_SY_EXTCLK];
	assign link_rise = sel_clk & ~lclk_prev_q;
	// conversion timing events
	assign conv_abort = (cv_st_q == `SALSR_CV_CONV) && start_fall;
	assign conv_done = (cv_st_q == `SALSR_CV_CONV) && !start_fall
		&& (conv_cnt_q == 8'h01) && fifo_in_ready;
	assign pre_point = (cv_st_q == `SALSR_CV_CONV) && (conv_cnt_q == PRE_CYC);
	// read start decisions
	assign rd_idle = (rd_st_q == `SALSR_RD_IDLE);
	assign read_now = rd_idle && cs_ok && rd_fall && (cv_st_q != `SALSR_CV_CONV);
	assign read_eoc = rd_idle && cs_ok && pre_point && !conv_abort
		&& (rd_pend_q || rd_fall || !sync2_q[`SALSR_SY_RD_N]);
	assign edge_nx = edge_q + 5'h01;
	// result register drains the buffer except while shifting
	assign fifo_out_ready = (rd_st_q != `SALSR_RD_SHIFT);
	salsr_fifo #(.WIDTH(`SALSR_WORD_W), .DEPTH(`SALSR_FIFO_DEPTH), .AW(`SALSR_FIFO_AW)) u_fifo (
		.clk(ref_clk),
		.nrst(nrst),
		.in_valid((cv_st_q == `SALSR_CV_CONV) && (conv_cnt_q == 8'h01) && !start_fall),
		.in_ready(fifo_in_ready),
		.in_data(sar_result),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	// edge history and link clock generation
	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			start_prev_q <= 1'b0;
			rd_n_prev_q <= 1'b1;
			int_clk_q <= 1'b0;
			lclk_prev_q <= 1'b0;
			link_clk_q <= 1'b0;
		end
		else
		begin
			start_prev_q <= start_lvl;
			rd_n_prev_q <= sync2_q[`SALSR_SY_RD_N];
			int_clk_q <= ~int_clk_q; // internal source, half the reference rate
			lclk_prev_q <= sel_clk;
			link_clk_q <= sel_clk; // clock output never tristates
		end
	end

	// sample and convert sequencing
	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cv_st_q <= `SALSR_CV_WAIT;
			conv_cnt_q <= 8'h00;
			sample_pend_q <= 1'b0;
			conv_active_q <= 1'b0;
			valid_q <= 1'b0;
			lp_q <= 1'b0;
		end
		else
		begin
			case (cv_st_q)
				`SALSR_CV_WAIT:
				begin
					if (start_rise)
					begin
						cv_st_q <= `SALSR_CV_SAMPLE;
						lp_q <= 1'b0;
					end
				end
				`SALSR_CV_SAMPLE:
				begin
					if (start_fall)
					begin
						cv_st_q <= `SALSR_CV_CONV;
						conv_cnt_q <= CONV_CYC;
						conv_active_q <= 1'b1;
					end
				end
				`SALSR_CV_CONV:
				begin
					if (start_rise)
						sample_pend_q <= 1'b1;
					if (conv_abort)
					begin
						cv_st_q <= `SALSR_CV_WAIT;
						conv_active_q <= 1'b0;
						sample_pend_q <= 1'b0;
						valid_q <= 1'b0;
					end
					else if (conv_done)
					begin
						conv_active_q <= 1'b0;
						valid_q <= 1'b1;
						sample_pend_q <= 1'b0;
						lp_q <= sync2_q[`SALSR_SY_LP] && !(sample_pend_q || start_rise);
						if (sample_pend_q || start_rise)
							cv_st_q <= `SALSR_CV_SAMPLE;
						else
							cv_st_q <= `SALSR_CV_WAIT;
					end
					else if (conv_cnt_q != 8'h01)
						conv_cnt_q <= conv_cnt_q - 8'h01; // holds at one while buffer full
				end
				default:
				begin
					cv_st_q <= `SALSR_CV_WAIT;
					conv_active_q <= 1'b0;
				end
			endcase
		end
	end

	// latest completed result, loaded from the buffer
	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			out_q <= 16'h0000;
		else if (fifo_out_valid && fifo_out_ready)
			out_q <= fifo_out_data;
	end

	// read request seen during conversion waits for the pre-end point
	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			rd_pend_q <= 1'b0;
		else
		begin
			if (!cs_ok || read_eoc || conv_abort || cv_st_q != `SALSR_CV_CONV)
				rd_pend_q <= 1'b0;
			if (cs_ok && rd_fall && rd_idle && cv_st_q == `SALSR_CV_CONV && !read_eoc)
				rd_pend_q <= 1'b1; // set wins over clear
		end
	end

	// read cycle: lead-in, marker rise, serial shifting
	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rd_st_q <= `SALSR_RD_IDLE;
			edge_q <= 5'h00;
			shift_q <= 16'h0000;
			frame_q <= 1'b0;
			frame_oe_q <= 1'b0;
			ser_q <= 1'b0;
			ser_oe_q <= 1'b0;
			bus_busy_q <= 1'b0;
			eoc_wait_q <= 1'b0;
		end
		else if (!cs_ok)
		begin
			rd_st_q <= `SALSR_RD_IDLE;
			frame_oe_q <= 1'b0;
			ser_oe_q <= 1'b0;
			frame_q <= 1'b0;
			ser_q <= 1'b0;
			bus_busy_q <= 1'b0;
			eoc_wait_q <= 1'b0;
		end
		else
		begin
			case (rd_st_q)
				`SALSR_RD_IDLE:
				begin
					if (read_now || read_eoc)
					begin
						rd_st_q <= `SALSR_RD_LEAD;
						frame_oe_q <= 1'b1;
						ser_oe_q <= 1'b1;
						bus_busy_q <= 1'b1;
						frame_q <= 1'b0;
						ser_q <= 1'b0;
						eoc_wait_q <= read_eoc;
					end
				end
				`SALSR_RD_LEAD:
				begin
					if (conv_done || conv_abort)
						eoc_wait_q <= 1'b0;
					if (link_rise && !eoc_wait_q && !fifo_out_valid)
					begin
						rd_st_q <= `SALSR_RD_SHIFT;
						frame_q <= 1'b1;
						edge_q <= 5'h00;
						shift_q <= out_q;
					end
				end
				`SALSR_RD_SHIFT:
				begin
					if (link_rise)
					begin
						edge_q <= edge_nx;
						frame_q <= frame_edge(edge_nx, sync2_q[`SALSR_SY_HALF]);
						if (edge_nx >= `SALSR_EDGE_MSB && edge_nx <= `SALSR_EDGE_LSB)
						begin
							ser_q <= shift_q[15];
							shift_q <= {shift_q[14:0], 1'b0};
						end
						if (edge_nx == `SALSR_EDGE_END)
						begin
							rd_st_q <= `SALSR_RD_IDLE;
							frame_oe_q <= 1'b0;
							ser_oe_q <= 1'b0;
							frame_q <= 1'b0;
							ser_q <= 1'b0;
							bus_busy_q <= 1'b0;
						end
					end
				end
				default:
				begin
					rd_st_q <= `SALSR_RD_IDLE;
					frame_oe_q <= 1'b0;
					ser_oe_q <= 1'b0;
					bus_busy_q <= 1'b0;
				end
			endcase
		end
	end

	// outputs straight from flip-flops
	assign conv_active = conv_active_q;
	assign bus_busy = bus_busy_q;
	assign result_valid = valid_q;
	assign low_power = lp_q;
	assign link_clk_out = link_clk_q;
	assign frame_out = frame_q;
	assign frame_out_oe = frame_oe_q;
	assign serial_out = ser_q;
	assign serial_out_oe = ser_oe_q;
endmodule // salsr_readout

// ===== verif/salsr_readout_assertions.sv
`timescale 1ns/1ps
// conversion and readout timing at the block pins
module salsr_readout_assertions (
	input wire ref_clk,
	input wire nrst,
	input wire lvds_convert_start,
	input wire cmos_convert_start,
	input wire rd_n,
	input wire cs_n,
	input wire half_frame_sel,
	input wire clk_src_sel,
	input wire conv_active,
	input wire bus_busy,
	input wire result_valid,
	input wire frame_out,
	input wire frame_out_oe,
	input wire serial_out_oe
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	reg [7:0] cv_q;
	reg [5:0] fg_q;
	reg fp_q;
	reg fs_q;
	wire st = lvds_convert_start | cmos_convert_start;
	wire fr = frame_out & ~fp_q;
	// conversion length, and ref cycles between marker rises in a read
	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cv_q <= 8'h00;
			fg_q <= 6'h00;
			fp_q <= 1'b0;
			fs_q <= 1'b0;
		end
		else
		begin
			cv_q <= conv_active ? cv_q + 8'h01 : 8'h00;
			fg_q <= fr ? 6'h01 : fg_q + 6'h01;
			fp_q <= frame_out;
			fs_q <= bus_busy & (fs_q | fr);
		end
	end
	sequence s_rd_req;
		$fell(rd_n) && !cs_n && !conv_active && !bus_busy;
	endsequence
	sequence s_rd_hold;
		(!cs_n && !conv_active)[*3];
	endsequence
	a_read_start: assert property (s_rd_req ##1 s_rd_hold |-> ##[0:2] bus_busy)
		else $error("read not started");
	a_read_init: assert property ($rose(bus_busy) |-> frame_out_oe && serial_out_oe && !frame_out)
		else $error("bad read start");
	a_busy_oe: assert property (bus_busy == frame_out_oe)
		else $error("busy and enable differ");
	a_cs_off: assert property (cs_n [*6] |-> !frame_out_oe && !serial_out_oe && !bus_busy)
		else $error("driven while deselected");
	a_conv_time: assert property ($fell(conv_active) && result_valid |-> cv_q == 8'h50)
		else $error("bad conversion length");
	a_abort_conv: assert property ($fell(st) && conv_active && cv_q < 8'h46 |-> ##[2:5] (!conv_active && !result_valid))
		else $error("abort not taken");
	a_pre_end: assert property ($rose(bus_busy) && conv_active |-> ##[8:12] !conv_active)
		else $error("bad pre-end read");
	a_frame_gap: assert property (fr && fs_q && clk_src_sel |-> fg_q == (half_frame_sel ? 6'h10 : 6'h20))
		else $error("bad marker period");
endmodule // salsr_readout_assertions

bind salsr_readout salsr_readout_assertions u_chk (.*);

// ===== verif/salsr_rx_model.sv
`timescale 1ns/1ps
// far-side deserialiser
module salsr_rx_model (
	input wire ref_clk,
	input wire link_clk_out,
	input wire frame_out,
	input wire serial_out,
	input wire serial_out_oe,
	output reg [15:0] word_q,
	output reg [7:0] hi_q,
	output reg [7:0] lo_q,
	output reg done_q
);
	reg lk_q;
	reg oe_q;
	reg [15:0] sh_q;
	reg [4:0] n_q;
	// shift on link falls, take the word when the line is released,
	// and a byte on the second link rise after each marker rise
	always @(posedge ref_clk)
	begin
		if (~lk_q & link_clk_out)
			n_q <= frame_out ? 5'h00 : n_q + 5'h01;
		if (~lk_q & link_clk_out & ~frame_out & oe_q & (n_q == 5'h01))
		begin
			hi_q <= lo_q;
			lo_q <= sh_q[7:0];
		end
		lk_q <= link_clk_out;
		oe_q <= serial_out_oe;
		done_q <= oe_q & ~serial_out_oe;
		if (lk_q & ~link_clk_out & serial_out_oe)
			sh_q <= {sh_q[14:0], serial_out};
		if (oe_q & ~serial_out_oe)
			word_q <= sh_q;
	end
endmodule // salsr_rx_model

// ===== verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	reg ref_clk, nrst, lvds_convert_start, cmos_convert_start, rd_n, cs_n;
	reg half_frame_sel, clk_src_sel, ext_clk_in, low_power_idle;
	reg [15:0] sar_result;
	wire conv_active, bus_busy, result_valid, low_power, link_clk_out;
	wire frame_out, frame_out_oe, serial_out, serial_out_oe, rx_done;
	wire [15:0] rx_word;
	wire [7:0] rx_hi, rx_lo;
	integer err_count, cmp_count;
	// block and far-side receiver
	salsr_readout DUT (.ref_clk, .nrst, .lvds_convert_start, .cmos_convert_start, .rd_n,
		.cs_n, .half_frame_sel, .clk_src_sel, .ext_clk_in, .low_power_idle, .sar_result,
		.conv_active, .bus_busy, .result_valid, .low_power, .link_clk_out, .frame_out,
		.frame_out_oe, .serial_out, .serial_out_oe); // lone device
	salsr_rx_model u_rx (.ref_clk, .link_clk_out, .frame_out, .serial_out, .serial_out_oe,
		.word_q(rx_word), .hi_q(rx_hi), .lo_q(rx_lo), .done_q(rx_done));
	// reference clock and an unrelated external link clock
	initial
	begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	initial
	begin
		ext_clk_in = 1'b0;
		#17.3;
		forever #62.5 ext_clk_in = ~ext_clk_in;
	end
	task chk(input string nm, input [15:0] got, input [15:0] exp);
	begin
		cmp_count = cmp_count + 1;
		if (got !== exp)
		begin
			err_count = err_count + 1;
			$display("ERROR %s exp %h got %h", nm, exp, got);
		end
	end
	endtask
	task final_report;
	begin
		if (err_count == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	end
	endtask
	task tick(input integer n);
		repeat (n) @(posedge ref_clk);
	endtask
	// bounded wait: 0 for conversion end, 1 for a received word
	task wait_for(input integer sel);
		integer i;
	begin
		i = 0;
		while (i < 4000 && !(sel ? rx_done === 1'b1 : conv_active === 1'b0))
		begin
			@(posedge ref_clk);
			i = i + 1;
		end
		if (i == 4000)
		begin
			err_count = err_count + 1;
			final_report;
		end
	end
	endtask
	task conv(input cm, input [15:0] v, input rdc);
	begin
		@(posedge ref_clk);
		sar_result <= v;
		if (cm)
			cmos_convert_start <= 1'b1;
		else
			lvds_convert_start <= 1'b1;
		tick(12);
		chk("low_power", low_power, 1'b0);
		lvds_convert_start <= 1'b0;
		cmos_convert_start <= 1'b0;
		tick(6);
		chk("conv_active", conv_active, 1'b1);
		if (rdc)
			rd_n <= 1'b0;
		wait_for(0);
		tick(2);
		chk("result_valid", result_valid, 1'b1);
	end
	endtask
	task rd(input [15:0] exp, input w);
	begin
		@(posedge ref_clk);
		rd_n <= 1'b0;
		wait_for(1);
		rd_n <= 1'b1;
		if (w)
			chk("rx_word", rx_word, exp);
		chk("bus_busy", bus_busy, 1'b0);
	end
	endtask
	task t_full;
	begin
		low_power_idle <= 1'b1;
		conv(1'b0, 16'hA5C3, 1'b0);
		chk("low_power", low_power, 1'b1);
		low_power_idle <= 1'b0;
		rd(16'hA5C3, 1'b1);
	end
	endtask
	task t_half;
	begin
		half_frame_sel <= 1'b1;
		conv(1'b1, 16'h3C96, 1'b0);
		rd(16'h3C96, 1'b1);
		chk("rx_bytes", {rx_hi, rx_lo}, 16'h3C96);
		half_frame_sel <= 1'b0;
	end
	endtask
	task t_int;
	begin
		clk_src_sel <= 1'b1;
		conv(1'b0, 16'h5A0F, 1'b0);
		rd(16'h5A0F, 1'b1);
		clk_src_sel <= 1'b0;
	end
	endtask
	task t_cs;
	begin
		@(posedge ref_clk);
		rd_n <= 1'b0;
		tick(60);
		cs_n <= 1'b1;
		tick(8);
		chk("frame_out_oe", frame_out_oe, 1'b0);
		chk("serial_out_oe", serial_out_oe, 1'b0);
		rd_n <= 1'b1;
		tick(2);
		cs_n <= 1'b0;
		tick(4);
		chk("bus_busy", bus_busy, 1'b0);
	end
	endtask
	task t_b2b;
	begin
		@(posedge ref_clk);
		lvds_convert_start <= 1'b1;
		tick(12);
		lvds_convert_start <= 1'b0;
		tick(40);
		lvds_convert_start <= 1'b1;
		wait_for(0);
		tick(6);
		lvds_convert_start <= 1'b0;
		tick(6);
		chk("conv_active", conv_active, 1'b1);
		wait_for(0);
	end
	endtask
	task t_abort;
	begin
		@(posedge ref_clk);
		lvds_convert_start <= 1'b1;
		tick(12);
		lvds_convert_start <= 1'b0;
		tick(20);
		lvds_convert_start <= 1'b1;
		tick(8);
		lvds_convert_start <= 1'b0;
		tick(8);
		chk("conv_active", conv_active, 1'b0);
		chk("result_valid", result_valid, 1'b0);
	end
	endtask
	task t_pre_end;
	begin
		conv(1'b0, 16'h7E81, 1'b1);
		chk("bus_busy", bus_busy, 1'b1);
		wait_for(1);
		rd_n <= 1'b1;
		chk("rx_word", rx_word, 16'h7E81);
	end
	endtask
	// reset, then each scenario in turn
	initial
	begin
		err_count = 0;
		cmp_count = 0;
		nrst = 1'b0;
		lvds_convert_start = 1'b0;
		cmos_convert_start = 1'b0;
		rd_n = 1'b1;
		cs_n = 1'b0;
		half_frame_sel = 1'b0;
		clk_src_sel = 1'b0;
		low_power_idle = 1'b0;
		sar_result = 16'h0000;
		tick(20);
		nrst <= 1'b1;
		tick(4);
		t_full;
		t_half;
		t_int;
		t_cs;
		t_b2b;
		t_abort;
		t_pre_end;
		final_report;
	end
endmodule // tb_top
